//--- dv/gpio_pin_model.sv
// partner: keys and signal sources driving the gpio pins
`timescale 1ns/100ps
module gpio_pin_model (
  // clock
  input wire logic clock,
  // requested pin levels
  input wire logic [31:0] pin_target,
  // pins into the block
  output logic [31:0] gpio_in = 32'h00FF_0000
);
  // pins follow pin_target one clock later, changing on the rising edge itself
  always @(posedge clock) begin
    gpio_in <= pin_target;
  end
endmodule

//--- dv/keypad_debounce_irq_assertions.sv
// checker: port-level assertions for the keypad debounce block
`timescale 1ns/100ps
module keypad_debounce_irq_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire keypad_debounce_pkg::bus_req_t bus_req,
  input wire logic [31:0] rdata,
  // pins and interrupts
  input wire logic [31:0] gpio_in,
  input wire logic keypad_interrupt,
  input wire logic [4:0] pin_line_interrupt
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // decoded register accesses
  // ----------------------------------------------------------------
  logic rd_stat; // status read strobe
  logic rd_clr; // clear register read strobe
  logic [4:0] clr; // line clear bits being written
  assign rd_stat = bus_req.read && bus_req.addr == keypad_debounce_pkg::ADDR_STATUS;
  assign rd_clr = bus_req.read && bus_req.addr == keypad_debounce_pkg::ADDR_LINE_CLEAR;
  assign clr = (bus_req.write && bus_req.addr == keypad_debounce_pkg::ADDR_LINE_CLEAR) ?
    bus_req.wdata[4:0] : 5'h00;
  // ----------------------------------------------------------------
  // register port and keypad
  // ----------------------------------------------------------------
  a_rdata_quiet: assert property (
    !bus_req.read |=> rdata == 32'h0) else $error("read data not zero outside read");
  a_clear_reads_zero: assert property (
    rd_clr |=> rdata == 32'h0) else $error("clear register read not zero");
  a_status_flags: assert property (
    rd_stat |=> rdata[4:0] == pin_line_interrupt) else $error("status flags mismatch");
  a_state_onehot: assert property (
    rd_stat |=> $onehot(rdata[12:8])) else $error("keypad state not one-hot");
  a_kp_one_cycle: assert property (
    keypad_interrupt |=> !keypad_interrupt) else $error("keypad pulse too long");
  // ----------------------------------------------------------------
  // line flags: sticky until cleared
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 5; i++) begin : g_line
    a_line_sticky: assert property (
      pin_line_interrupt[i] && !clr[i] && !$past(clr[i]) |=> pin_line_interrupt[i])
      else $error("line flag dropped without clear");
    a_line_clear_drop: assert property (
      pin_line_interrupt[i] && clr[i] && !$past(clr[i]) |=> ##1 !pin_line_interrupt[i])
      else $error("line flag survived clear");
    a_line_rise_hold: assert property (
      $rose(pin_line_interrupt[i]) && !clr[i] && !$past(clr[i])
      |-> pin_line_interrupt[i] [*2]) else $error("line flag glitched");
  end
  c_keypad: cover property (keypad_interrupt);
  c_line: cover property (|pin_line_interrupt);
  c_status: cover property (rd_stat ##1 rdata[4:0] != 5'h00);
endmodule

bind keypad_debounce_irq keypad_debounce_irq_checker u_checker (
  .clock(clock), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata), .gpio_in(gpio_in),
  .keypad_interrupt(keypad_interrupt), .pin_line_interrupt(pin_line_interrupt));

//--- dv/keypad_debounce_irq_bench.sv
// testbench: register and pin sequences for the keypad debounce block
`timescale 1ns/100ps
module keypad_debounce_irq_bench;
  // ----------------------------------------------------------------
  // signals and bookkeeping
  // ----------------------------------------------------------------
  logic clock;
  logic rst_n;
  keypad_debounce_pkg::bus_req_t bus_req;
  logic [31:0] rdata;
  logic [31:0] gpio_in;
  logic [31:0] pin_target; // keys on 16..23 idle high, lines on 8..12 idle low
  logic keypad_interrupt;
  logic [4:0] pin_line_interrupt;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0; // cycle stamp
  int t0; // press stamp
  int gap; // spacing of keypad pulses
  int kp_times[$]; // stamps of keypad pulses
  logic [7:0] addrs[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h30};

  keypad_debounce_irq u_dut (.clock(clock), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
    .gpio_in(gpio_in), .keypad_interrupt(keypad_interrupt),
    .pin_line_interrupt(pin_line_interrupt));
  gpio_pin_model u_pins (.clock(clock), .pin_target(pin_target), .gpio_in(gpio_in));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // stamp every keypad pulse
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (keypad_interrupt === 1'b1) kp_times.push_back(cyc);
  end
  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus_req <= '0;
  endtask
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    bus_req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock);
    bus_req <= '0;
    #1 d = rdata;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_read(a, d);
    check("register", exp, d);
  endtask
  // move one pin, then count keypad pulses over 40 cycles
  task automatic pin_step(input int p, input logic v, input int exp);
    kp_times.delete();
    @(posedge clock);
    pin_target[p] <= v;
    repeat (40) @(posedge clock);
    check("keypad pulses", 32'(exp), 32'(kp_times.size()));
  endtask
  task automatic line_after(input logic [4:0] exp);
    repeat (10) @(posedge clock);
    #1 check("line interrupt", {27'h0, exp}, {27'h0, pin_line_interrupt});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // hang guard, well past the longest test
  initial begin
    #(90000 * 50);
    failures++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    bus_req = '0;
    rst_n = 1'b0;
    pin_target = 32'h00FF_0000;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    // reset values, write-only and unmapped places read zero
    foreach (addrs[i]) check_reg(addrs[i], 32'h0);
    check_reg(keypad_debounce_pkg::ADDR_STATUS, 32'h0000_0100);
    $display("test reset done");
    // keypad without debounce: pin 19 enabled, release on, no repeat
    bus_write(keypad_debounce_pkg::ADDR_KEYPAD_PINS, 32'h0008_0000);
    bus_write(keypad_debounce_pkg::ADDR_KEYPAD_CONFIG, 32'h0000_0200);
    pin_step(21, 1'b0, 0);
    pin_step(21, 1'b1, 0);
    pin_step(19, 1'b0, 1);
    pin_step(19, 1'b0, 0);
    pin_step(19, 1'b1, 1);
    bus_write(keypad_debounce_pkg::ADDR_KEYPAD_CONFIG, 32'h0000_0000);
    pin_step(19, 1'b0, 1);
    pin_step(19, 1'b1, 0);
    // active high: park pin 19 low while not enabled
    bus_write(keypad_debounce_pkg::ADDR_KEYPAD_PINS, 32'h0);
    bus_write(keypad_debounce_pkg::ADDR_KEYPAD_CONFIG, 32'h0000_0100);
    pin_step(19, 1'b0, 0);
    bus_write(keypad_debounce_pkg::ADDR_KEYPAD_PINS, 32'h0008_0000);
    pin_step(19, 1'b1, 1);
    pin_step(19, 1'b0, 0);
    $display("test keypad done");
    // one-millisecond debounce and repeat on pin 18, line 0 debounced too
    bus_write(keypad_debounce_pkg::ADDR_KEYPAD_PINS, 32'h0004_0000);
    bus_write(keypad_debounce_pkg::ADDR_KEYPAD_CONFIG, 32'h0000_0001);
    for (int n = 0; n < 5; n++) begin
      bus_write(keypad_debounce_pkg::ADDR_SRC_BASE + 8'(4 * n), 32'(8 + n));
    end
    check_reg(keypad_debounce_pkg::ADDR_SRC_BASE + 8'h10, 32'h0000_000C);
    bus_write(keypad_debounce_pkg::ADDR_DEBOUNCE, 32'h0000_2101);
    kp_times.delete();
    @(posedge clock);
    pin_target[18] <= 1'b0;
    pin_target[8] <= 1'b1;
    t0 = cyc;
    repeat (45000) @(posedge clock);
    #1;
    gap = (kp_times.size() >= 2) ? kp_times[1] - kp_times[0] : -1;
    check("pulse spacing", 32'(keypad_debounce_pkg::TICK_CYCLES), 32'(gap));
    check("press delay", 32'h1, 32'((kp_times[0] - t0) <= 20010));
    check("line debounced", 32'h1, {31'h0, pin_line_interrupt[0]});
    pin_target[8] <= 1'b0;
    pin_target[18] <= 1'b1;
    // stop repeats and debounce before the clear, so line 0 cannot re-arm on a stale pin
    bus_write(keypad_debounce_pkg::ADDR_KEYPAD_CONFIG, 32'h0);
    bus_write(keypad_debounce_pkg::ADDR_DEBOUNCE, 32'h0);
    bus_write(keypad_debounce_pkg::ADDR_LINE_CLEAR, 32'h1);
    line_after(5'h00);
    // the pending repeat countdown needs one more tick to fall back to idle
    repeat (keypad_debounce_pkg::TICK_CYCLES) @(posedge clock);
    check_reg(keypad_debounce_pkg::ADDR_STATUS, 32'h0000_0100);
    $display("test debounce done");
    // every line: level restart, edge wait, both-edge capture by polarity flip
    for (int n = 0; n < 5; n++) begin
      bus_write(keypad_debounce_pkg::ADDR_LINE_MODE, 32'h0);
      @(posedge clock);
      pin_target[8 + n] <= 1'b1;
      line_after(5'(1 << n));
      check_reg(keypad_debounce_pkg::ADDR_STATUS, 32'h100 | 32'(1 << n));
      bus_write(keypad_debounce_pkg::ADDR_LINE_CLEAR, 32'(1 << n));
      @(posedge clock);
      #1 check("line dip", 32'h0, {27'h0, pin_line_interrupt});
      line_after(5'(1 << n));
      bus_write(keypad_debounce_pkg::ADDR_LINE_MODE, 32'(1 << (8 + n)));
      bus_write(keypad_debounce_pkg::ADDR_LINE_CLEAR, 32'(1 << n));
      line_after(5'h00);
      bus_write(keypad_debounce_pkg::ADDR_LINE_MODE, 32'(1 << (8 + n)) | 32'(1 << n));
      @(posedge clock);
      pin_target[8 + n] <= 1'b0;
      line_after(5'(1 << n));
      bus_write(keypad_debounce_pkg::ADDR_LINE_MODE, 32'h0);
      bus_write(keypad_debounce_pkg::ADDR_LINE_CLEAR, 32'(1 << n));
      line_after(5'h00);
    end
    $display("test lines done");
    give_verdict();
  end
endmodule

//--- rtl/keypad_debounce_irq.sv
// keyboard scanner with debounce and five single-pin interrupt lines
`timescale 1ns/100ps

module keypad_debounce_irq (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire keypad_debounce_pkg::bus_req_t bus_req,
  output logic [31:0] rdata,
  // gpio pins from outside
  input wire logic [31:0] gpio_in,
  // interrupt outputs
  output logic keypad_interrupt,
  output logic [4:0] pin_line_interrupt
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0] gpio_meta;                     // first synchroniser stage
  logic [31:0] gpio_sync;                     // second synchroniser stage
  logic [5:0] repeat_time;                    // key repeat interval, ms
  logic keypad_polarity;                      // 0 = active low keys
  logic release_report_enable;                // report key release
  logic [31:0] keypad_pin_enable;             // per-pin scanner enables
  logic [5:0] debounce_time;                  // shared debounce time, ms
  logic [4:0] line_debounce_enable;           // per-line debounce enable
  logic keypad_debounce_enable;               // scanner debounce enable
  logic [4:0] line_polarity;                  // 0 = active high line
  logic [4:0] line_edge_mode;                 // 1 = edge, 0 = level
  logic [4:0] line_source_select [5];         // per-line pin select
  logic [4:0] line_clear;                     // clear pulses from a write
  logic [14:0] prescale;                      // tick prescaler
  logic tick;                                 // one-cycle 1 ms tick
  logic key_hit;                              // any enabled key active
  keypad_debounce_pkg::keypad_state_t kp_state; // scanner state
  logic [5:0] kp_timer;                       // scanner countdown
  logic [4:0] line_flag;                      // sticky line flags
  logic [4:0] line_hit;                       // per-line hit detect

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  // two flops before any logic looks at a pin
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gpio_meta <= 32'h0000_0000;
      gpio_sync <= 32'h0000_0000;
    end else begin
      gpio_meta <= gpio_in;
      gpio_sync <= gpio_meta;
    end
  end

  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  // free-running prescaler shared by all timers
  // tick phase is free, so a count of n lasts between n-1 and n ms
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= 15'h0000;
      tick <= 1'b0;
    end else if (prescale == 15'(keypad_debounce_pkg::TICK_CYCLES - 1)) begin
      prescale <= 15'h0000;
      tick <= 1'b1;
    end else begin
      prescale <= prescale + 15'h0001;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // configuration registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      repeat_time <= 6'h00;
      keypad_polarity <= 1'b0;
      release_report_enable <= 1'b0;
      keypad_pin_enable <= 32'h0000_0000;
      debounce_time <= 6'h00;
      line_debounce_enable <= 5'h00;
      keypad_debounce_enable <= 1'b0;
      line_polarity <= 5'h00;
      line_edge_mode <= 5'h00;
    end else if (bus_req.write) begin
      case (bus_req.addr)
        keypad_debounce_pkg::ADDR_KEYPAD_CONFIG: begin
          repeat_time <= bus_req.wdata[keypad_debounce_pkg::CFG_REPEAT_LSB +: 6];
          keypad_polarity <= bus_req.wdata[keypad_debounce_pkg::CFG_POLARITY_BIT];
          release_report_enable <= bus_req.wdata[keypad_debounce_pkg::CFG_RELEASE_BIT];
        end
        keypad_debounce_pkg::ADDR_KEYPAD_PINS: begin
          keypad_pin_enable <= bus_req.wdata;
        end
        keypad_debounce_pkg::ADDR_DEBOUNCE: begin
          debounce_time <= bus_req.wdata[keypad_debounce_pkg::DEB_TIME_LSB +: 6];
          line_debounce_enable <= bus_req.wdata[keypad_debounce_pkg::DEB_LINE_LSB +: 5];
          keypad_debounce_enable <= bus_req.wdata[keypad_debounce_pkg::DEB_KEYPAD_BIT];
        end
        keypad_debounce_pkg::ADDR_LINE_MODE: begin
          line_polarity <= bus_req.wdata[keypad_debounce_pkg::MODE_POL_LSB +: 5];
          line_edge_mode <= bus_req.wdata[keypad_debounce_pkg::MODE_EDGE_LSB +: 5];
        end
        default: begin
          // other addresses hold no configuration here
        end
      endcase
    end
  end

  // clear pulses: ones written to the clear register
  // clears only act in the flagged state, so set and clear never meet
  always_comb begin
    if (bus_req.write && bus_req.addr == keypad_debounce_pkg::ADDR_LINE_CLEAR) begin
      line_clear = bus_req.wdata[4:0];
    end else begin
      line_clear = 5'h00;
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (!bus_req.read) begin
      rdata <= 32'h0000_0000;
    end else begin
      case (bus_req.addr)
        keypad_debounce_pkg::ADDR_KEYPAD_CONFIG: begin
          rdata <= {22'h000000, release_report_enable, keypad_polarity, 2'h0, repeat_time};
        end
        keypad_debounce_pkg::ADDR_KEYPAD_PINS: begin
          rdata <= keypad_pin_enable;
        end
        keypad_debounce_pkg::ADDR_DEBOUNCE: begin
          rdata <= {18'h00000, keypad_debounce_enable, line_debounce_enable, 2'h0,
                    debounce_time};
        end
        keypad_debounce_pkg::ADDR_LINE_MODE: begin
          rdata <= {19'h00000, line_edge_mode, 3'h0, line_polarity};
        end
        keypad_debounce_pkg::ADDR_STATUS: begin
          rdata <= {19'h00000, kp_state, 3'h0, line_flag};
        end
        keypad_debounce_pkg::ADDR_SRC_BASE,
        keypad_debounce_pkg::ADDR_SRC_BASE + 8'h04,
        keypad_debounce_pkg::ADDR_SRC_BASE + 8'h08,
        keypad_debounce_pkg::ADDR_SRC_BASE + 8'h0C,
        keypad_debounce_pkg::ADDR_SRC_BASE + 8'h10: begin
          rdata <= {27'h0000000, line_source_select[3'(bus_req.addr[4:2])]};
        end
        default: begin
          rdata <= 32'h0000_0000; // unmapped reads as zero
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // keyboard scanner
  // ----------------------------------------------------------------
  // hit when any enabled pin sits at the active level
  // level sensed: a key already down when enabled starts a sequence
  always_comb begin
    if (keypad_polarity) begin
      key_hit = |(gpio_sync & keypad_pin_enable);
    end else begin
      key_hit = |(~gpio_sync & keypad_pin_enable);
    end
  end

  // scanner state machine and countdown
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      kp_state <= keypad_debounce_pkg::KP_IDLE;
      kp_timer <= 6'h00;
      keypad_interrupt <= 1'b0;
    end else begin
      keypad_interrupt <= 1'b0;
      case (kp_state)
        keypad_debounce_pkg::KP_IDLE: begin
          if (key_hit) begin
            kp_timer <= keypad_debounce_enable ? debounce_time : 6'h00;
            kp_state <= keypad_debounce_pkg::KP_PRESS;
          end
        end
        keypad_debounce_pkg::KP_PRESS, keypad_debounce_pkg::KP_REPEAT: begin
          if (kp_timer != 6'h00) begin
            if (tick) begin
              kp_timer <= kp_timer - 6'h01;
            end
          end else if (!key_hit) begin
            // bounce or release seen once the countdown has expired
            kp_state <= keypad_debounce_pkg::KP_IDLE;
            if (kp_state == keypad_debounce_pkg::KP_REPEAT && release_report_enable) begin
              kp_timer <= keypad_debounce_enable ? debounce_time : 6'h00;
              kp_state <= keypad_debounce_pkg::KP_RELEASE;
            end
          end else begin
            keypad_interrupt <= 1'b1;
            kp_timer <= repeat_time;
            if (kp_state == keypad_debounce_pkg::KP_REPEAT && repeat_time == 6'h00) begin
              keypad_interrupt <= 1'b0;
            end
            kp_state <= (repeat_time == 6'h00) ? keypad_debounce_pkg::KP_HELD
                                               : keypad_debounce_pkg::KP_REPEAT;
          end
        end
        keypad_debounce_pkg::KP_HELD: begin
          if (!key_hit) begin
            if (release_report_enable) begin
              kp_timer <= keypad_debounce_enable ? debounce_time : 6'h00;
              kp_state <= keypad_debounce_pkg::KP_RELEASE;
            end else begin
              kp_state <= keypad_debounce_pkg::KP_IDLE;
            end
          end
        end
        // release debounce does not recheck the key; it always reports
        keypad_debounce_pkg::KP_RELEASE: begin
          if (kp_timer != 6'h00) begin
            if (tick) begin
              kp_timer <= kp_timer - 6'h01;
            end
          end else begin
            keypad_interrupt <= 1'b1;
            kp_state <= keypad_debounce_pkg::KP_IDLE;
          end
        end
        default: begin
          kp_state <= keypad_debounce_pkg::KP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // single-pin interrupt lines
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < keypad_debounce_pkg::NUM_LINES; g++) begin : gen_line
      keypad_debounce_pkg::line_state_t state; // line state
      logic [5:0] timer;                       // line countdown

      // selected pin at its active level
      assign line_hit[g] = gpio_sync[line_source_select[g]] ^ line_polarity[g];
      // line state stays internal; status shows only the flags

      // source select register for this line
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          line_source_select[g] <= 5'h00;
        end else if (bus_req.write &&
                     bus_req.addr == keypad_debounce_pkg::ADDR_SRC_BASE + 8'(4 * g)) begin
          line_source_select[g] <= bus_req.wdata[4:0];
        end
      end

      // line state machine
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          state <= keypad_debounce_pkg::LN_IDLE;
          timer <= 6'h00;
          line_flag[g] <= 1'b0;
        end else begin
          case (state)
            keypad_debounce_pkg::LN_IDLE: begin
              if (line_hit[g]) begin
                timer <= line_debounce_enable[g] ? debounce_time : 6'h00;
                state <= keypad_debounce_pkg::LN_DEBOUNCE;
              end
            end
            keypad_debounce_pkg::LN_DEBOUNCE: begin
              if (timer != 6'h00) begin
                if (tick) begin
                  timer <= timer - 6'h01;
                end
              end else if (line_hit[g]) begin
                line_flag[g] <= 1'b1;
                state <= keypad_debounce_pkg::LN_FLAGGED;
              end else begin
                state <= keypad_debounce_pkg::LN_IDLE;
              end
            end
            keypad_debounce_pkg::LN_FLAGGED: begin
              if (line_clear[g]) begin
                line_flag[g] <= 1'b0;
                state <= line_edge_mode[g] ? keypad_debounce_pkg::LN_RELEASE
                                           : keypad_debounce_pkg::LN_IDLE;
              end
            end
            keypad_debounce_pkg::LN_RELEASE: begin
              if (!line_hit[g]) begin
                state <= keypad_debounce_pkg::LN_IDLE;
              end
            end
            default: begin
              state <= keypad_debounce_pkg::LN_IDLE;
            end
          endcase
        end
      end

      // interrupt output follows the sticky flag
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          pin_line_interrupt[g] <= 1'b0;
        end else begin
          pin_line_interrupt[g] <= line_flag[g];
        end
      end
    end
  endgenerate

endmodule

//--- rtl/keypad_debounce_pkg.sv
// package: constants, register map and carrier types for the keypad debounce block
package keypad_debounce_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 20000000;                 // block clock rate
  localparam int TICK_TIME_US = 1000;                 // debounce tick, 1 ms
  localparam int TICK_CYCLES = (CLOCK_HZ / 1000000) * TICK_TIME_US; // cycles per tick
  localparam int MAX_DEBOUNCE_MS = 63;                // longest debounce time

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 32;                       // monitored gpio inputs
  localparam int NUM_LINES = 5;                       // single-pin interrupt lines
  localparam int TIME_W = 6;                          // debounce and repeat field width
  localparam int SEL_W = 5;                           // source select width

  // ----------------------------------------------------------------
  // register byte addresses (word index = byte address / 4)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_KEYPAD_CONFIG = 8'h00;  // polarity, release, repeat
  localparam logic [7:0] ADDR_KEYPAD_PINS = 8'h04;    // keypad pin enables
  localparam logic [7:0] ADDR_DEBOUNCE = 8'h08;       // debounce time and enables
  localparam logic [7:0] ADDR_LINE_MODE = 8'h0C;      // polarity and edge mode per line
  localparam logic [7:0] ADDR_LINE_CLEAR = 8'h10;     // write ones to clear line flags
  localparam logic [7:0] ADDR_STATUS = 8'h14;         // read-only state
  localparam logic [7:0] ADDR_SRC_BASE = 8'h20;       // line source select, 4 per line

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_REPEAT_LSB = 0;                  // repeat interval [5:0]
  localparam int CFG_POLARITY_BIT = 8;                // keypad polarity
  localparam int CFG_RELEASE_BIT = 9;                 // release report enable
  localparam int DEB_TIME_LSB = 0;                    // debounce time [5:0]
  localparam int DEB_LINE_LSB = 8;                    // line debounce enables [12:8]
  localparam int DEB_KEYPAD_BIT = 13;                 // keypad debounce enable
  localparam int MODE_POL_LSB = 0;                    // line polarity [4:0]
  localparam int MODE_EDGE_LSB = 8;                   // line edge mode [12:8]
  localparam int STAT_FLAG_LSB = 0;                   // line flags [4:0]
  localparam int STAT_KEYPAD_LSB = 8;                 // keypad state code [12:8]

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000; // every config register resets to 0

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    KP_IDLE = 5'h01,     // waiting for an active key
    KP_PRESS = 5'h02,    // debouncing the press
    KP_REPEAT = 5'h04,   // key held, repeat timing
    KP_HELD = 5'h08,     // key held, no repeat
    KP_RELEASE = 5'h10   // debouncing the release
  } keypad_state_t;

  typedef enum logic [3:0] {
    LN_IDLE = 4'h1,      // waiting for active level
    LN_DEBOUNCE = 4'h2,  // counting down
    LN_FLAGGED = 4'h4,   // flag set, awaiting clear
    LN_RELEASE = 4'h8    // awaiting non-active input
  } line_state_t;

  // register bus request carrier
  typedef struct packed {
    logic write;         // write strobe
    logic read;          // read strobe
    logic [7:0] addr;    // byte address
    logic [31:0] wdata;  // write data
  } bus_req_t;

endpackage
